// File: bsel_boot_select.sv
// Boot source selection, ROM initialisation sequencer and APB register slave
`timescale 1ns/1ps
module bsel_boot_select
(
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst_b,
  input  wire logic                      i_por_rst_b,
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [bsel_pkg::BSEL_AW-1:0] i_paddr,
  input  wire logic [bsel_pkg::BSEL_DW-1:0] i_pwdata,
  output logic      [bsel_pkg::BSEL_DW-1:0] o_prdata,
  output logic                           o_pready,
  output logic                           o_pslverr,
  input  wire logic                      i_external_access_pin,
  input  wire logic                      i_loader_select_pin,
  input  wire logic                      i_netboot_select_pin,
  input  wire logic                      i_baud_detected,
  input  wire logic                      i_banner_done,
  output logic                           o_fetch_start,
  output logic                           o_fetch_from_rom,
  output logic      [23:0]               o_fetch_addr,
  output logic                           o_rom_accessible,
  output logic      [23:0]               o_rom_base,
  output logic                           o_init_done,
  output logic      [1:0]                o_boot_path,
  output logic                           o_loader_start,
  output logic                           o_serial_monitor,
  output logic                           o_send_banner,
  output logic                           o_cmd_enable,
  output logic                           o_netboot_start,
  output logic                           o_search_start,
  output logic      [7:0]                o_address_control,
  output logic      [7:0]                o_port4_control,
  output logic      [7:0]                o_port5_control,
  output logic      [7:0]                o_port6_control,
  output logic      [7:0]                o_memory_control,
  output logic      [7:0]                o_clock_control,
  output logic      [7:0]                o_uart_mode
);
  import bsel_pkg::*;

  bsel_state_t state;
  bsel_state_t next_state;
  logic [3:0]  step;
  logic [7:0]  cfg [BSEL_N_CFG];
  logic        rom_bypass_bit;
  logic        baud_ok;
  logic [2:0]  init_sel;
  logic [7:0]  init_val;

  // Bus decode
  wire        acc       = i_psel & i_penable;
  wire        acc_first = acc & ~o_pready;
  wire        wr_commit = acc & o_pready & i_pwrite;
  wire        hit_ctrl  = (i_paddr == BSEL_OFF_CTRL);
  wire        hit_stat  = (i_paddr == BSEL_OFF_STATUS);
  wire        hit_cfg   = (i_paddr >= BSEL_OFF_CFG) && (i_paddr < BSEL_OFF_CFG_END) && (i_paddr[1:0] == 2'h0);
  wire [7:0]  cfg_off   = i_paddr - BSEL_OFF_CFG;
  wire [2:0]  cfg_idx   = cfg_off[4:2];
  wire        mapped    = hit_ctrl | hit_stat | hit_cfg;
  wire        bad_wr    = i_pwrite & hit_stat;
  wire [31:0] ctrl_word = {31'h0, rom_bypass_bit};
  wire [31:0] stat_word = {26'h0, o_cmd_enable, i_external_access_pin, o_boot_path, o_init_done, o_fetch_from_rom};
  wire [31:0] cfg_word  = {24'h0, cfg[cfg_idx]};
  wire [31:0] rd_word   = hit_ctrl ? ctrl_word :
                          hit_stat ? stat_word :
                          hit_cfg  ? cfg_word  : 32'h0;

  // Sequencer decisions
  wire        in_init   = (state == BSEL_ST_INIT);
  wire        init_last = in_init && (step == BSEL_INIT_LAST);
  wire        rom_path  = i_external_access_pin & ~rom_bypass_bit;
  wire        in_serial = (o_boot_path == BSEL_PATH_SERIAL);

  bsel_init_step u_step
  (
    .i_step  (step),
    .i_address_control_reg  (cfg[BSEL_CFG_ADDRESS_CONTROL_REG]),
    .i_clock_control_reg (cfg[BSEL_CFG_CLOCK_CONTROL_REG]),
    .o_sel   (init_sel),
    .o_value (init_val)
  );

  // APB answer: one wait state, so the error code is ready with pready
  wire        next_err   = acc_first & (~mapped | bad_wr);
  wire [31:0] next_rdata = (acc_first & ~i_pwrite) ? rd_word : 32'h0;

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready  <= acc_first;
      o_pslverr <= next_err;
    end
  end

  // Read data is zero outside the answer cycle so stale words never leak
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_prdata <= 32'h0;
    end
    else
    begin
      o_prdata <= next_rdata;
    end
  end

  // Only a power-on reset clears the bypass choice
  always_ff @(posedge i_clk_sys or negedge i_por_rst_b)
  begin
    if (!i_por_rst_b)
    begin
      rom_bypass_bit <= BSEL_BYPASS_RST;
    end
    else if (wr_commit && hit_ctrl)
    begin
      rom_bypass_bit <= i_pwdata[BSEL_CTRL_BYPASS];
    end
  end

  // Configuration registers; the init sequence wins over a software write
  for (genvar g = 0; g < BSEL_N_CFG; g++)
  begin : g_cfg
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
      if (!i_rst_b)
      begin
        cfg[g] <= BSEL_CFG_RST;
      end
      else if (in_init && (init_sel == 3'(g)))
      begin
        cfg[g] <= init_val;
      end
      else if (wr_commit && hit_cfg && (cfg_idx == 3'(g)))
      begin
        cfg[g] <= i_pwdata[7:0];
      end
    end
  end

  assign o_address_control = cfg[BSEL_CFG_ADDRESS_CONTROL_REG];
  assign o_port4_control   = cfg[BSEL_CFG_P4];
  assign o_port5_control   = cfg[BSEL_CFG_P5];
  assign o_port6_control   = cfg[BSEL_CFG_P6];
  assign o_memory_control  = cfg[BSEL_CFG_MEMORY_CONTROL_REG];
  assign o_clock_control   = cfg[BSEL_CFG_CLOCK_CONTROL_REG];
  assign o_uart_mode       = cfg[BSEL_CFG_UART];

  always_comb
  begin
    next_state = state;
    case (state)
      BSEL_ST_IDLE:
      begin
        next_state = BSEL_ST_DECIDE;
      end
      BSEL_ST_DECIDE:
      begin
        next_state = rom_path ? BSEL_ST_INIT : BSEL_ST_EXTERN;
      end
      BSEL_ST_INIT:
      begin
        next_state = init_last ? BSEL_ST_PINS : BSEL_ST_INIT;
      end
      BSEL_ST_PINS:
      begin
        next_state = BSEL_ST_RUN;
      end
      BSEL_ST_RUN:
      begin
        next_state = BSEL_ST_RUN;
      end
      default:
      begin
        next_state = BSEL_ST_EXTERN;
      end
    endcase
  end

  wire [3:0]  next_step = in_init ? step + 4'h1 : 4'h0;

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state <= BSEL_ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Step count restarts whenever the sequencer is outside INIT
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      step <= 4'h0;
    end
    else
    begin
      step <= next_step;
    end
  end

  // Boot decisions as named wires; the registers below only capture them
  wire        at_decide = (state == BSEL_ST_DECIDE);
  wire        at_pins   = (state == BSEL_ST_PINS);
  wire        pick_load = i_loader_select_pin;
  wire        pick_net  = ~i_loader_select_pin & ~i_netboot_select_pin;
  wire        pick_find = ~i_loader_select_pin & i_netboot_select_pin;
  wire [1:0]  next_path = pick_load ? BSEL_PATH_SERIAL :
                          pick_net  ? BSEL_PATH_NET    : BSEL_PATH_SEARCH;
  wire [23:0] next_base = cfg[BSEL_CFG_ADDRESS_CONTROL_REG][BSEL_ADDRESS_CONTROL_REG_RELOC] ? BSEL_ROM_RELOC : BSEL_RESET_ADDR;

  // First fetch always at address zero of the chosen space
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_fetch_start    <= 1'b0;
      o_fetch_from_rom <= 1'b0;
      o_fetch_addr     <= BSEL_RESET_ADDR;
    end
    else
    begin
      o_fetch_start <= at_decide;
      o_fetch_addr  <= BSEL_RESET_ADDR;
      if (at_decide)
      begin
        o_fetch_from_rom <= rom_path;
      end
    end
  end

  // Pin low hides the ROM even after the ROM path was taken
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rom_accessible <= 1'b0;
      o_rom_base       <= BSEL_RESET_ADDR;
    end
    else
    begin
      o_rom_accessible <= o_fetch_from_rom & i_external_access_pin;
      o_rom_base       <= next_base;
    end
  end

  // Done holds until the next reset so software can poll it
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_init_done <= 1'b0;
    end
    else if (init_last)
    begin
      o_init_done <= 1'b1;
    end
  end

  // Straps are read once, in the cycle after init ends
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_boot_path <= BSEL_PATH_NONE;
    end
    else if (at_pins)
    begin
      o_boot_path <= next_path;
    end
  end

  // One-cycle start pulses; the three outcomes exclude each other
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_loader_start  <= 1'b0;
      o_netboot_start <= 1'b0;
      o_search_start  <= 1'b0;
    end
    else
    begin
      o_loader_start  <= at_pins & pick_load;
      o_netboot_start <= at_pins & pick_net;
      o_search_start  <= at_pins & pick_find;
    end
  end

  // Banner is asked for once; later baud hits are ignored
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_serial_monitor <= 1'b0;
      o_send_banner    <= 1'b0;
    end
    else
    begin
      o_serial_monitor <= in_serial & ~o_cmd_enable;
      o_send_banner    <= in_serial & ~baud_ok & i_baud_detected;
    end
  end

  // Commands stay locked until the banner is out
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      baud_ok      <= 1'b0;
      o_cmd_enable <= 1'b0;
    end
    else
    begin
      if (in_serial && i_baud_detected)
      begin
        baud_ok <= 1'b1;
      end
      if (in_serial && baud_ok && i_banner_done)
      begin
        o_cmd_enable <= 1'b1;
      end
    end
  end
endmodule

// File: bsel_pkg.sv
// Constants, register map and state encoding for the boot source selector
package bsel_pkg;
  localparam int          BSEL_AW          = 8;
  localparam int          BSEL_DW          = 32;
  // Register byte offsets
  localparam logic [7:0]  BSEL_OFF_CTRL    = 8'h00;
  localparam logic [7:0]  BSEL_OFF_STATUS  = 8'h04;
  localparam logic [7:0]  BSEL_OFF_CFG     = 8'h08;
  localparam int          BSEL_N_CFG       = 7;
  localparam logic [7:0]  BSEL_OFF_CFG_END = 8'h24;
  // Configuration register indices (offset = BSEL_OFF_CFG + 4 * index)
  localparam logic [2:0]  BSEL_CFG_ADDRESS_CONTROL_REG    = 3'h0;
  localparam logic [2:0]  BSEL_CFG_P4      = 3'h1;
  localparam logic [2:0]  BSEL_CFG_P5      = 3'h2;
  localparam logic [2:0]  BSEL_CFG_P6      = 3'h3;
  localparam logic [2:0]  BSEL_CFG_MEMORY_CONTROL_REG    = 3'h4;
  localparam logic [2:0]  BSEL_CFG_CLOCK_CONTROL_REG   = 3'h5;
  localparam logic [2:0]  BSEL_CFG_UART    = 3'h6;
  // Reset values
  localparam logic [7:0]  BSEL_CFG_RST     = 8'h00;
  localparam logic        BSEL_BYPASS_RST  = 1'b0;
  // Control and status field positions
  localparam int          BSEL_CTRL_BYPASS = 0;
  localparam int          BSEL_ST_ROM      = 0;
  localparam int          BSEL_ST_DONE     = 1;
  localparam int          BSEL_ST_PATH_LO  = 2;
  localparam int          BSEL_ST_EA       = 4;
  localparam int          BSEL_ST_CMD      = 5;
  // Initialisation values
  localparam logic [1:0]  BSEL_ADDRESS_CONTROL_REG_AM24   = 2'h3;
  localparam int          BSEL_ADDRESS_CONTROL_REG_RELOC  = 5;
  localparam int          BSEL_ADDRESS_CONTROL_REG_XSTK   = 2;
  localparam logic [7:0]  BSEL_P4_INIT     = 8'h2f;
  localparam logic [7:0]  BSEL_P5_INIT     = 8'h07;
  localparam logic [7:0]  BSEL_P6_INIT     = 8'h27;
  localparam logic [7:0]  BSEL_MEMORY_CONTROL_REG_INIT   = 8'haf;
  localparam logic [2:0]  BSEL_CK_STRETCH  = 3'h7;
  localparam logic [1:0]  BSEL_UART_MODE1  = 2'h1;
  localparam logic [3:0]  BSEL_INIT_LAST   = 4'h8;
  // Fetch addresses
  localparam logic [23:0] BSEL_RESET_ADDR  = 24'h000000;
  localparam logic [23:0] BSEL_ROM_RELOC   = 24'hff0000;
  // Boot path codes
  typedef enum logic [1:0] {
    BSEL_PATH_NONE   = 2'h0,
    BSEL_PATH_SERIAL = 2'h1,
    BSEL_PATH_NET    = 2'h2,
    BSEL_PATH_SEARCH = 2'h3
  } bsel_path_t;
  // Gray coded along idle, decide, init, pins, run
  typedef enum logic [2:0] {
    BSEL_ST_IDLE   = 3'h0,
    BSEL_ST_DECIDE = 3'h1,
    BSEL_ST_INIT   = 3'h3,
    BSEL_ST_PINS   = 3'h2,
    BSEL_ST_RUN    = 3'h6,
    BSEL_ST_EXTERN = 3'h4
  } bsel_state_t;
endpackage

// File: bsel_init_step.sv
// Step table of the ROM initialisation sequence
`timescale 1ns/1ps
module bsel_init_step
(
  input  wire logic [3:0] i_step,
  input  wire logic [7:0] i_address_control_reg,
  input  wire logic [7:0] i_clock_control_reg,
  output logic      [2:0] o_sel,
  output logic      [7:0] o_value
);
  import bsel_pkg::*;
  // Read-modify-write steps keep the untouched bits of the target
  always_comb
  begin
    o_sel   = BSEL_CFG_ADDRESS_CONTROL_REG;
    o_value = i_address_control_reg;
    case (i_step)
      4'h0:
      begin
        o_value = {i_address_control_reg[7:2], BSEL_ADDRESS_CONTROL_REG_AM24};
      end
      4'h1:
      begin
        o_value = i_address_control_reg | (8'h01 << BSEL_ADDRESS_CONTROL_REG_RELOC);
      end
      4'h2:
      begin
        o_sel   = BSEL_CFG_P4;
        o_value = BSEL_P4_INIT;
      end
      4'h3:
      begin
        o_sel   = BSEL_CFG_P5;
        o_value = BSEL_P5_INIT;
      end
      4'h4:
      begin
        o_sel   = BSEL_CFG_P6;
        o_value = BSEL_P6_INIT;
      end
      4'h5:
      begin
        o_sel   = BSEL_CFG_MEMORY_CONTROL_REG;
        o_value = BSEL_MEMORY_CONTROL_REG_INIT;
      end
      4'h6:
      begin
        o_value = i_address_control_reg | (8'h01 << BSEL_ADDRESS_CONTROL_REG_XSTK);
      end
      4'h7:
      begin
        o_sel   = BSEL_CFG_CLOCK_CONTROL_REG;
        o_value = {i_clock_control_reg[7:3], BSEL_CK_STRETCH};
      end
      default:
      begin
        o_sel   = BSEL_CFG_UART;
        o_value = {4'h0, BSEL_UART_MODE1, BSEL_UART_MODE1};
      end
    endcase
  end
endmodule

// File: bsel_boot_monitor.sv
// Concurrent checks on the boot selector ports
`timescale 1ns/1ps
module bsel_boot_monitor
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  input  wire logic       i_external_access_pin,
  input  wire logic       i_loader_select_pin,
  input  wire logic       i_netboot_select_pin,
  input  wire logic       i_banner_done,
  input  wire logic       o_fetch_start,
  input  wire logic       o_fetch_from_rom,
  input  wire logic       o_rom_accessible,
  input  wire logic [23:0] o_rom_base,
  input  wire logic       o_init_done,
  input  wire logic [1:0] o_boot_path,
  input  wire logic       o_loader_start,
  input  wire logic       o_netboot_start,
  input  wire logic       o_search_start,
  input  wire logic       o_cmd_enable,
  input  wire logic [7:0] o_address_control,
  input  wire logic [7:0] o_port4_control,
  input  wire logic [7:0] o_port5_control,
  input  wire logic [7:0] o_port6_control,
  input  wire logic [7:0] o_memory_control,
  input  wire logic [7:0] o_clock_control,
  input  wire logic [7:0] o_uart_mode
);
  import bsel_pkg::*;
  default clocking mon_cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);
  // Release edge, then IDLE to DECIDE, then the pulse shows one edge later
  AST_FETCH_START: assert property ($rose(i_rst_b) |-> ##2 o_fetch_start)
    else $error("fetch start missing after reset");
  AST_EA_LOW: assert property (o_fetch_start && !i_external_access_pin |-> !o_fetch_from_rom)
    else $error("rom fetch with access pin low");
  AST_EA_ACCESS: assert property (!$past(i_external_access_pin) |-> !o_rom_accessible)
    else $error("rom reachable with access pin low");
  AST_ROM_FLOW: assert property (o_fetch_start && o_fetch_from_rom |-> ##9 o_init_done
    ##1 (o_loader_start || o_netboot_start || o_search_start))
    else $error("rom path sequence wrong");
  AST_EXT_FLOW: assert property (o_fetch_start && !o_fetch_from_rom |=> !o_init_done [*8])
    else $error("init ran on external path");
  // Pulses come one edge after the straps were read
  AST_LOADER: assert property (o_loader_start |-> $past(i_loader_select_pin))
    else $error("loader started with pin low");
  AST_NETBOOT: assert property (o_netboot_start |-> !$past(i_loader_select_pin)
    && !$past(i_netboot_select_pin))
    else $error("network boot on wrong straps");
  AST_SEARCH: assert property (o_search_start |-> !$past(i_loader_select_pin)
    && $past(i_netboot_select_pin))
    else $error("code search on wrong straps");
  AST_CMD: assert property ($rose(o_cmd_enable) |-> $past(i_banner_done) && o_boot_path == BSEL_PATH_SERIAL)
    else $error("commands enabled before banner");
  AST_ADDRESS_CONTROL_REG: assert property ($rose(o_init_done) |-> o_address_control == 8'h27)
    else $error("address control wrong after init");
  AST_ROM_BASE: assert property ($rose(o_address_control[5]) |=> o_rom_base == BSEL_ROM_RELOC)
    else $error("rom base not relocated");
  AST_CFG: assert property ($rose(o_init_done) |-> o_port4_control == 8'h2f
    && o_port5_control == 8'h07 && o_port6_control == 8'h27 && o_memory_control == 8'haf
    && o_clock_control[2:0] == 3'h7 && o_uart_mode == 8'h05)
    else $error("configuration wrong after init");
endmodule
bind bsel_boot_select bsel_boot_monitor bsel_boot_monitor_i (.i_clk_sys, .i_rst_b, .i_external_access_pin,
  .i_loader_select_pin, .i_netboot_select_pin, .i_banner_done, .o_fetch_start, .o_fetch_from_rom,
  .o_rom_accessible, .o_rom_base, .o_init_done, .o_boot_path, .o_loader_start, .o_netboot_start,
  .o_search_start, .o_cmd_enable, .o_address_control, .o_port4_control, .o_port5_control,
  .o_port6_control, .o_memory_control, .o_clock_control, .o_uart_mode);

// File: bsel_strap_model.sv
// Strap pins and serial host outside the boot selector
`timescale 1ns/1ps
module bsel_strap_model
(
  input  wire logic       i_clk_sys,
  input  wire logic [2:0] i_straps,
  input  wire logic       i_host_go,
  input  wire logic       i_send_banner,
  output logic            o_access_pin,
  output logic            o_loader_pin,
  output logic            o_netboot_pin,
  output logic            o_baud_detected,
  output logic            o_banner_done
);
  logic [2:0] wait_cnt = 3'h0;
  logic       seen     = 1'b0;
  assign o_access_pin    = i_straps[2];
  assign o_loader_pin    = i_straps[1];
  assign o_netboot_pin   = i_straps[0];
  assign o_baud_detected = i_host_go;
  // Banner takes a few cycles; the host answers only once all of it arrived
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_host_go)
    begin
      seen     <= 1'b0;
      wait_cnt <= 3'h0;
    end
    else if (i_send_banner)
      seen <= 1'b1;
    else if (seen && wait_cnt != 3'h4)
      wait_cnt <= wait_cnt + 3'h1;
  end
  assign o_banner_done = seen && (wait_cnt == 3'h4);
endmodule

// File: tb_top.sv
// Self-checking bench for the boot source selector
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module tb_top;
  import bsel_pkg::*;
  logic        i_clk_sys, i_rst_b, i_por_rst_b, i_psel, i_penable, i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic        o_pready, o_pslverr, er, host_go;
  logic        i_external_access_pin, i_loader_select_pin, i_netboot_select_pin;
  logic        i_baud_detected, i_banner_done, o_fetch_start, o_fetch_from_rom;
  logic [23:0] o_fetch_addr, o_rom_base;
  logic        o_rom_accessible, o_init_done, o_loader_start, o_serial_monitor;
  logic        o_send_banner, o_cmd_enable, o_netboot_start, o_search_start;
  logic [1:0]  o_boot_path;
  logic [7:0]  o_address_control, o_port4_control, o_port5_control, o_port6_control;
  logic [7:0]  o_memory_control, o_clock_control, o_uart_mode;
  logic [2:0]  straps;
  logic [6:0]  r;
  int          n_fail, comparisons, cyc;
  // Row: access, bypass, loader, netboot, from_rom, path[1:0]; serial row last
  logic [6:0]  rows [6] = '{7'h10, 7'h38, 7'h60, 7'h46, 7'h4f, 7'h55};
  logic [7:0]  cfg_exp [7] = '{8'h27, BSEL_P4_INIT, BSEL_P5_INIT, BSEL_P6_INIT, BSEL_MEMORY_CONTROL_REG_INIT, 8'h07, 8'h05};
  bsel_boot_select bsel_boot_select_i (.i_clk_sys, .i_rst_b, .i_por_rst_b, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_external_access_pin, .i_loader_select_pin,
    .i_netboot_select_pin, .i_baud_detected, .i_banner_done, .o_fetch_start, .o_fetch_from_rom,
    .o_fetch_addr, .o_rom_accessible, .o_rom_base, .o_init_done, .o_boot_path, .o_loader_start,
    .o_serial_monitor, .o_send_banner, .o_cmd_enable, .o_netboot_start, .o_search_start,
    .o_address_control, .o_port4_control, .o_port5_control, .o_port6_control, .o_memory_control,
    .o_clock_control, .o_uart_mode);
  bsel_strap_model bsel_strap_model_i (.i_clk_sys, .i_straps(straps), .i_host_go(host_go),
    .i_send_banner(o_send_banner), .o_access_pin(i_external_access_pin), .o_loader_pin(i_loader_select_pin),
    .o_netboot_pin(i_netboot_select_pin), .o_baud_detected(i_baud_detected), .o_banner_done(i_banner_done));
  initial
  begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  task automatic test_done;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      test_done;
    end
  end
  task automatic rst(input logic por);
    i_rst_b     <= 1'b0;
    i_por_rst_b <= !por;
    repeat (6) @(posedge i_clk_sys);
    i_rst_b     <= 1'b1;
    i_por_rst_b <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_psel    <= 1'b1;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    // No assumed latency: a slave that never answers is caught by the hang guard
    do
    begin
      @(posedge i_clk_sys);
    end
    while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  initial
  begin
    {i_rst_b, i_por_rst_b, i_psel, i_penable, i_pwrite, host_go} = 6'h00;
    i_paddr  = 8'h00;
    i_pwdata = 32'h0;
    straps   = 3'h0;
    rst(1'b1);
    foreach (rows[j])
    begin
      r = rows[j];
      straps <= {r[6], r[4], r[3]};
      rst(1'b0);
      apb(1'b1, BSEL_OFF_CTRL, {31'h0, r[5]});
      rst(1'b0);
      repeat (14) @(posedge i_clk_sys);
      `CHK("from_rom", r[2], o_fetch_from_rom)
      `CHK("accessible", r[2], o_rom_accessible)
      `CHK("path", r[1:0], o_boot_path)
      `CHK("init_done", r[2], o_init_done)
      `CHK("fetch_addr", 24'h0, o_fetch_addr)
      `CHK("cmd_enable", 1'b0, o_cmd_enable)
      $display("row %0d done", j);
    end
    `CHK("monitor_on", 1'b1, o_serial_monitor)
    host_go <= 1'b1;
    repeat (12) @(posedge i_clk_sys);
    `CHK("cmd_enable", 1'b1, o_cmd_enable)
    `CHK("monitor", 1'b0, o_serial_monitor)
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, 8'(BSEL_OFF_CFG + 4 * i), 32'h0);
      `CHK("cfg", cfg_exp[i], rd[7:0])
    end
    apb(1'b0, BSEL_OFF_STATUS, 32'h0);
    `CHK("status", 8'h37, rd[7:0])
    $display("serial and init test done");
    apb(1'b1, BSEL_OFF_STATUS, 32'h0);
    `CHK("status_write_err", 1'b1, er)
    apb(1'b0, 8'h80, 32'h0);
    `CHK("unmapped_err", 1'b1, er)
    apb(1'b1, BSEL_OFF_CTRL, 32'h1);
    rst(1'b1);
    apb(1'b0, BSEL_OFF_CTRL, 32'h0);
    `CHK("bypass_after_por", 1'b0, rd[0])
    $display("error and power-on test done");
    test_done;
  end
endmodule
